// ---- src/cpc_ctrl.sv ----
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
module cpc_ctrl (
   input  wire logic                i_core_clk,
   input  wire logic                i_rstn,
   input  wire logic                i_hsel,
   input  wire logic [31:0]         i_haddr,
   input  wire logic [1:0]          i_htrans,
   input  wire logic                i_hwrite,
   input  wire logic [2:0]          i_hsize,
   input  wire logic [31:0]         i_hwdata,
   input  wire logic                i_hready,
   output logic      [31:0]         o_hrdata,
   output logic                     o_hreadyout,
   output logic                     o_hresp,
   input  wire logic                i_mclk,
   input  wire logic                i_locked_loop_synth_clk,
   output logic                     o_left_phones_out_en,
   output logic                     o_right_phones_out_en,
   output logic                     o_left_line_drive_en,
   output logic                     o_right_line_drive_en,
   output logic                     o_left_playback_conv_en,
   output logic                     o_right_playback_conv_en,
   output logic                     o_left_record_conv_en,
   output logic                     o_right_record_conv_en,
   output logic                     o_core_clock,
   output logic                     o_core_clk_gated,
   output logic                     o_dsp_clk_gated,
   output logic                     o_pin_clk_out,
   output logic                     o_timeout_clock,
   output cpc_pkg::cpc_ratio_type   o_core_to_fs_ratio,
   output logic [2:0]               o_sample_rate_code,
   output logic                     o_sample_rate_valid
);

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------
   // Zero wait states. Read data is taken from the next register values, so a
   // read right behind a write to the same register already sees new data.
   logic [15:0]  reg_ff  [cpc_pkg::NUM_REGS];
   logic [15:0]  nxt_reg [cpc_pkg::NUM_REGS];
   logic         wr_pend_ff;
   logic         nxt_wr_pend;
   logic [7:0]   wr_idx_ff;
   logic [7:0]   nxt_wr_idx;
   logic [31:0]  hrdata_ff;
   logic [31:0]  nxt_hrdata;
   logic         addr_ph;

   assign addr_ph     = i_hsel && i_htrans[1] && i_hready;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   assign o_hrdata    = hrdata_ff;

   always_comb begin
      nxt_wr_pend = addr_ph && i_hwrite && i_haddr[31:10] == 22'h00_0000;
      nxt_wr_idx  = addr_ph ? i_haddr[9:2] : wr_idx_ff;
      nxt_hrdata  = hrdata_ff;
      if (addr_ph && !i_hwrite) begin
         nxt_hrdata = 32'h0000_0000;
         for (int k = 0; k < cpc_pkg::NUM_REGS; k++) begin
            if (i_haddr[31:2] == {22'h00_0000, cpc_pkg::REG_IDX[k]}) begin
               nxt_hrdata = {16'h0000, nxt_reg[k]};
            end
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         wr_pend_ff <= 1'b0;
         wr_idx_ff  <= 8'h00;
         hrdata_ff  <= 32'h0000_0000;
      end else begin
         wr_pend_ff <= nxt_wr_pend;
         wr_idx_ff  <= nxt_wr_idx;
         hrdata_ff  <= nxt_hrdata;
      end
   end

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   // Reserved bits are masked on write and so always read as zero.
   for (genvar g = 0; g < cpc_pkg::NUM_REGS; g++) begin : g_reg
      always_comb begin
         nxt_reg[g] = reg_ff[g];
         if (wr_pend_ff && wr_idx_ff == cpc_pkg::REG_IDX[g]) begin
            nxt_reg[g] = i_hwdata[15:0] & cpc_pkg::REG_MASK[g];
         end
      end
      always_ff @(posedge i_core_clk) begin
         if (!i_rstn) begin
            reg_ff[g] <= cpc_pkg::REG_RESET[g];
         end else begin
            reg_ff[g] <= nxt_reg[g];
         end
      end
   end

   assign o_left_phones_out_en     = reg_ff[cpc_pkg::SLOT_HP][cpc_pkg::B_LEFT];
   assign o_right_phones_out_en    = reg_ff[cpc_pkg::SLOT_HP][cpc_pkg::B_RIGHT];
   assign o_left_line_drive_en     = reg_ff[cpc_pkg::SLOT_LINE][cpc_pkg::B_LEFT];
   assign o_right_line_drive_en    = reg_ff[cpc_pkg::SLOT_LINE][cpc_pkg::B_RIGHT];
   assign o_left_playback_conv_en  = reg_ff[cpc_pkg::SLOT_CONV][cpc_pkg::B_PLAY_L];
   assign o_right_playback_conv_en = reg_ff[cpc_pkg::SLOT_CONV][cpc_pkg::B_PLAY_R];
   assign o_left_record_conv_en    = reg_ff[cpc_pkg::SLOT_CONV][cpc_pkg::B_REC_L];
   assign o_right_record_conv_en   = reg_ff[cpc_pkg::SLOT_CONV][cpc_pkg::B_REC_R];

   logic         to_div16;
   logic         to_x4;
   logic         mclk_halve;
   logic [3:0]   ratio_code;
   logic [2:0]   fs_code;
   logic         master_clk_invert;
   logic         src_sel;
   logic         to_bypass;
   logic         to_en;

   assign to_div16   = reg_ff[cpc_pkg::SLOT_A][cpc_pkg::B_TO_DIV16];
   assign to_x4      = reg_ff[cpc_pkg::SLOT_A][cpc_pkg::B_TO_X4];
   assign mclk_halve = reg_ff[cpc_pkg::SLOT_A][cpc_pkg::B_MCLK_HALVE];
   assign ratio_code = reg_ff[cpc_pkg::SLOT_B][cpc_pkg::F_RATIO_LSB +: 4];
   assign fs_code    = reg_ff[cpc_pkg::SLOT_B][cpc_pkg::F_FS_LSB +: 3];
   assign master_clk_invert   = reg_ff[cpc_pkg::SLOT_C][cpc_pkg::B_MASTER_CLK_INVERT];
   assign src_sel    = reg_ff[cpc_pkg::SLOT_C][cpc_pkg::B_SRC_SEL];
   assign to_bypass  = reg_ff[cpc_pkg::SLOT_C][cpc_pkg::B_TO_BYPASS];
   assign to_en      = reg_ff[cpc_pkg::SLOT_C][cpc_pkg::B_TO_EN];

   // ----------------------------------------------------------------------
   // Core clock path
   // ----------------------------------------------------------------------
   // The clock inputs are sampled levels, so the generated clocks are only
   // faithful for sources well below half the core rate.
   logic                    src_ff;
   logic                    nxt_src;
   logic                    src_d_ff;
   logic                    half_ff;
   logic                    nxt_half;
   cpc_pkg::cpc_ratio_type  ratio_ff;
   cpc_pkg::cpc_ratio_type  nxt_ratio;
   logic [2:0]              fs_ff;
   logic                    fs_ok_ff;
   logic                    nxt_fs_ok;

   always_comb begin
      nxt_src  = src_sel ? i_locked_loop_synth_clk : (i_mclk ^ master_clk_invert);
      nxt_half = half_ff ^ (src_ff && !src_d_ff);
      case (ratio_code)
         4'h0:    nxt_ratio = 11'd64;
         4'h1:    nxt_ratio = 11'd128;
         4'h2:    nxt_ratio = 11'd192;
         4'h3:    nxt_ratio = 11'd256;
         4'h4:    nxt_ratio = 11'd384;
         4'h5:    nxt_ratio = 11'd512;
         4'h6:    nxt_ratio = 11'd768;
         4'h7:    nxt_ratio = 11'd1024;
         4'h8:    nxt_ratio = 11'd1408;
         4'h9:    nxt_ratio = 11'd1536;
         default: nxt_ratio = 11'd0;
      endcase
      nxt_fs_ok = fs_code <= cpc_pkg::FS_LAST_CODE;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         src_ff   <= 1'b0;
         src_d_ff <= 1'b0;
         half_ff  <= 1'b0;
         ratio_ff <= 11'd0;
         fs_ff    <= 3'h0;
         fs_ok_ff <= 1'b0;
      end else begin
         src_ff   <= nxt_src;
         src_d_ff <= src_ff;
         half_ff  <= nxt_half;
         ratio_ff <= nxt_ratio;
         fs_ff    <= fs_code;
         fs_ok_ff <= nxt_fs_ok;
      end
   end

   assign o_core_clock        = mclk_halve ? half_ff : src_ff;
   assign o_core_clk_gated    = o_core_clock && reg_ff[cpc_pkg::SLOT_C][cpc_pkg::B_CORE_GATE];
   assign o_dsp_clk_gated     = o_core_clock && reg_ff[cpc_pkg::SLOT_C][cpc_pkg::B_DSP_GATE];
   assign o_pin_clk_out       = o_core_clock && reg_ff[cpc_pkg::SLOT_C][cpc_pkg::B_PIN_CLK];
   assign o_core_to_fs_ratio  = ratio_ff;
   assign o_sample_rate_code  = fs_ff;
   assign o_sample_rate_valid = fs_ok_ff;

   // ----------------------------------------------------------------------
   // Zero-cross timeout clock
   // ----------------------------------------------------------------------
   // One-cycle tick per timeout period. A shorter new period takes effect at
   // once because the counter compares with greater-or-equal.
   logic [11:0]  to_period;
   logic [11:0]  to_cnt_ff;
   logic [11:0]  nxt_to_cnt;
   logic         to_tick_ff;
   logic         nxt_to_tick;

   always_comb begin
      to_period = cpc_pkg::TO_BASE_CYC;
      if (!to_bypass) begin
         to_period = {to_period[10:0], 1'b0};
      end
      if (to_div16) begin
         to_period = {to_period[7:0], 4'h0};
      end
      if (to_x4) begin
         to_period = {2'b00, to_period[11:2]};
      end
      nxt_to_cnt  = 12'h000;
      nxt_to_tick = 1'b0;
      if (to_en) begin
         if (to_cnt_ff + 12'h001 >= to_period) begin
            nxt_to_tick = 1'b1;
         end else begin
            nxt_to_cnt = to_cnt_ff + 12'h001;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         to_cnt_ff  <= 12'h000;
         to_tick_ff <= 1'b0;
      end else begin
         to_cnt_ff  <= nxt_to_cnt;
         to_tick_ff <= nxt_to_tick;
      end
   end

   assign o_timeout_clock = to_tick_ff;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   logic [11:0]  gap_ff;
   logic         gap_ok_ff;

   always_ff @(posedge i_core_clk) begin
      if (!i_rstn || to_tick_ff) begin
         gap_ff    <= 12'h000;
         gap_ok_ff <= to_tick_ff;
      end else begin
         gap_ff    <= gap_ff + 12'h001;
         gap_ok_ff <= gap_ok_ff && $stable(to_period) && to_en;
      end
   end

   sequence s_write(logic [7:0] idx);
      i_hsel && i_htrans == 2'b10 && i_hwrite && i_hready && i_haddr[31:2] == {22'h00_0000, idx} ##1 1'b1;
   endsequence

   property p_phones_write;
      @(posedge i_core_clk) disable iff (!i_rstn)
      s_write(cpc_pkg::IDX_HP_PWR) |=> o_left_phones_out_en == $past(i_hwdata[1])
                                       && o_right_phones_out_en == $past(i_hwdata[0]);
   endproperty
   a_phones_write: assert property (p_phones_write) else $error("headphone enable not written");

   property p_line_write;
      @(posedge i_core_clk) disable iff (!i_rstn)
      s_write(cpc_pkg::IDX_LINE_PWR) |=> o_left_line_drive_en == $past(i_hwdata[1])
                                         && o_right_line_drive_en == $past(i_hwdata[0]);
   endproperty
   a_line_write: assert property (p_line_write) else $error("line enable not written");

   property p_conv_write;
      @(posedge i_core_clk) disable iff (!i_rstn)
      s_write(cpc_pkg::IDX_CONV_PWR) |=> {o_left_playback_conv_en, o_right_playback_conv_en,
                                          o_left_record_conv_en, o_right_record_conv_en} == $past(i_hwdata[3:0]);
   endproperty
   a_conv_write: assert property (p_conv_write) else $error("converter enable not written");

   property p_to_gap;
      @(posedge i_core_clk) disable iff (!i_rstn)
      to_tick_ff && gap_ok_ff |-> gap_ff + 12'h001 == to_period;
   endproperty
   a_to_gap: assert property (p_to_gap) else $error("timeout period wrong");

   property p_mclk_direct;
      @(posedge i_core_clk) disable iff (!i_rstn)
      i_rstn && !mclk_halve && !src_sel && !master_clk_invert ##1 !mclk_halve && !src_sel && !master_clk_invert
      |-> o_core_clock == $past(i_mclk);
   endproperty
   a_mclk_direct: assert property (p_mclk_direct) else $error("core clock not master clock");

   property p_mclk_halve;
      @(posedge i_core_clk) disable iff (!i_rstn)
      mclk_halve && src_ff && !src_d_ff ##1 mclk_halve |-> o_core_clock != $past(o_core_clock);
   endproperty
   a_mclk_halve: assert property (p_mclk_halve) else $error("halved clock did not toggle");

   property p_ratio_top;
      @(posedge i_core_clk) disable iff (!i_rstn)
      ratio_code == 4'h9 |=> o_core_to_fs_ratio == 11'd1536;
   endproperty
   a_ratio_top: assert property (p_ratio_top) else $error("ratio decode wrong");

   property p_fs_reserved;
      @(posedge i_core_clk) disable iff (!i_rstn)
      i_rstn |=> o_sample_rate_code == $past(fs_code) && o_sample_rate_valid == ($past(fs_code[2:1]) != 2'b11);
   endproperty
   a_fs_reserved: assert property (p_fs_reserved) else $error("sample rate decode wrong");

   property p_src_pick;
      @(posedge i_core_clk) disable iff (!i_rstn)
      src_sel |=> src_ff == $past(i_locked_loop_synth_clk);
   endproperty
   a_src_pick: assert property (p_src_pick) else $error("source select wrong");

   property p_gates;
      @(posedge i_core_clk) disable iff (!i_rstn)
      !reg_ff[cpc_pkg::SLOT_C][cpc_pkg::B_CORE_GATE] |-> !o_core_clk_gated;
   endproperty
   a_gates: assert property (p_gates) else $error("core clock not gated");

   property p_to_off;
      @(posedge i_core_clk) disable iff (!i_rstn)
      !to_en ##1 !to_en |-> !o_timeout_clock;
   endproperty
   a_to_off: assert property (p_to_off) else $error("timeout ticks while off");

endmodule // cpc_ctrl

// ---- src/cpc_pkg.sv ----
package cpc_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   // Register indices; the byte address on the bus is four times the index.
   localparam int                NUM_REGS      = 6;
   localparam logic [7:0]        IDX_HP_PWR    = 8'h0e;
   localparam logic [7:0]        IDX_LINE_PWR  = 8'h0f;
   localparam logic [7:0]        IDX_CONV_PWR  = 8'h12;
   localparam logic [7:0]        IDX_CLK_A     = 8'h14;
   localparam logic [7:0]        IDX_CLK_B     = 8'h15;
   localparam logic [7:0]        IDX_CLK_C     = 8'h16;
   localparam logic [7:0]        REG_IDX  [NUM_REGS] = '{IDX_HP_PWR, IDX_LINE_PWR, IDX_CONV_PWR,
                                                         IDX_CLK_A, IDX_CLK_B, IDX_CLK_C};
   // Slots of the register array.
   localparam int                SLOT_HP       = 0;
   localparam int                SLOT_LINE     = 1;
   localparam int                SLOT_CONV     = 2;
   localparam int                SLOT_A        = 3;
   localparam int                SLOT_B        = 4;
   localparam int                SLOT_C        = 5;
   // Writable bits; all others are reserved and read as zero.
   localparam logic [15:0]       REG_MASK [NUM_REGS] = '{16'h0003, 16'h0003, 16'h000f,
                                                         16'h6001, 16'h3c07, 16'hd00f};
   localparam logic [15:0]       REG_RESET[NUM_REGS] = '{16'h0000, 16'h0000, 16'h0000,
                                                         16'h0000, 16'h0c05, 16'h0000};

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int                B_LEFT        = 1;
   localparam int                B_RIGHT       = 0;
   localparam int                B_PLAY_L      = 3;
   localparam int                B_PLAY_R      = 2;
   localparam int                B_REC_L       = 1;
   localparam int                B_REC_R       = 0;
   localparam int                B_TO_DIV16    = 14;
   localparam int                B_TO_X4       = 13;
   localparam int                B_MCLK_HALVE  = 0;
   localparam int                F_RATIO_LSB   = 10;
   localparam int                F_FS_LSB      = 0;
   localparam int                B_MASTER_CLK_INVERT    = 15;
   localparam int                B_SRC_SEL     = 14;
   localparam int                B_TO_BYPASS   = 12;
   localparam int                B_PIN_CLK     = 3;
   localparam int                B_CORE_GATE   = 2;
   localparam int                B_DSP_GATE    = 1;
   localparam int                B_TO_EN       = 0;
   localparam logic [2:0]        FS_LAST_CODE  = 3'h5;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int                CLK_PERIOD_NS = 100;
   // Unscaled timeout period before the doubling stage, in ns and then in core cycles.
   localparam int                TO_BASE_NS    = 6400;
   localparam logic [11:0]       TO_BASE_CYC   = 12'(TO_BASE_NS / CLK_PERIOD_NS);

   typedef logic [10:0] cpc_ratio_type;

endpackage

// ---- test/cpc_mclk_src.sv ----
`timescale 1ns/1ps
module cpc_mclk_src #(
   parameter int HALF_MC = 4,
   parameter int HALF_LL = 3
) (
   input  wire logic i_core_clk,
   output logic      o_mclk,
   output logic      o_ll_clk
);
   // ----------------------------------------------------------------------
   // Free-running clock sources
   // ----------------------------------------------------------------------
   int mc_cnt = 0;
   int ll_cnt = 0;
   logic mc_q = 1'b0;
   logic ll_q = 1'b0;

   // Both sources step just after a core edge, so the block never samples a level in transition.
   assign o_mclk = mc_q;
   assign o_ll_clk = ll_q;

   always @(posedge i_core_clk) begin
      mc_cnt <= (mc_cnt == HALF_MC - 1) ? 0 : mc_cnt + 1;
      ll_cnt <= (ll_cnt == HALF_LL - 1) ? 0 : ll_cnt + 1;
      if (mc_cnt == HALF_MC - 1) mc_q <= ~mc_q;
      if (ll_cnt == HALF_LL - 1) ll_q <= ~ll_q;
   end
endmodule // cpc_mclk_src

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   // ----------------------------------------------------------------------
   // Bench state
   // ----------------------------------------------------------------------
   logic        i_core_clk;
   logic        i_rstn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] o_hrdata;
   logic        hready;
   logic        o_hresp;
   logic        mclk;
   logic        ll_clk;
   logic [7:0]  en;
   logic [10:0] ratio;
   logic [2:0]  rcode;
   logic        rvalid;
   logic [3:0]  ck;
   logic        to_clk;
   logic        rd_ph;
   logic        look;
   logic        core_q;
   logic        e;
   logic [35:0] note;
   logic [31:0] obs;
   logic [35:0] notes[$];
   logic [15:0] sh[6];
   logic [15:0] lf;
   int          n_fail = 0;
   int          checks_done = 0;
   int          rises = 0, pulses = 0, gap = 0, cyc = 0, last_to = 0, base = 0, p0 = 0;
   int          rt[10] = '{64, 128, 192, 256, 384, 512, 768, 1024, 1408, 1536};

   cpc_ctrl dut (
      .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(o_hrdata),
      .o_hreadyout(hready), .o_hresp(o_hresp), .i_mclk(mclk), .i_locked_loop_synth_clk(ll_clk),
      .o_left_phones_out_en(en[7]), .o_right_phones_out_en(en[6]), .o_left_line_drive_en(en[5]),
      .o_right_line_drive_en(en[4]), .o_left_playback_conv_en(en[3]), .o_right_playback_conv_en(en[2]),
      .o_left_record_conv_en(en[1]), .o_right_record_conv_en(en[0]), .o_core_clock(ck[3]),
      .o_core_clk_gated(ck[2]), .o_dsp_clk_gated(ck[1]), .o_pin_clk_out(ck[0]), .o_timeout_clock(to_clk),
      .o_core_to_fs_ratio(ratio), .o_sample_rate_code(rcode), .o_sample_rate_valid(rvalid)
   );

   cpc_mclk_src #(.HALF_MC(4), .HALF_LL(3)) u_src (.i_core_clk(i_core_clk), .o_mclk(mclk), .o_ll_clk(ll_clk));

   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end

   function automatic logic [15:0] nxt_rand(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   function automatic logic [31:0] exp_stat();
      logic [3:0] c;
      logic [2:0] r;
      c = sh[4][13:10];
      r = sh[4][2:0];
      return {9'h0, sh[0][1:0], sh[1][1:0], sh[2][3:0], (c <= 9) ? 11'(rt[c]) : 11'h0, r, r <= 3'h5};
   endfunction

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] x);
      @(posedge i_core_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge i_core_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      if (!wr) begin
         notes.push_back({4'h0, x});
         rd_ph <= 1'b1;
      end
      do @(posedge i_core_clk); while (hready !== 1'b1);
      rd_ph <= 1'b0;
   endtask

   task automatic wr(input int s, input logic [31:0] d);
      bus(1'b1, 32'(cpc_pkg::REG_IDX[s]) << 2, d, 32'h0);
      sh[s] = d[15:0] & cpc_pkg::REG_MASK[s];
   endtask

   task automatic rd(input int s);
      bus(1'b0, 32'(cpc_pkg::REG_IDX[s]) << 2, 32'h0, {16'h0, sh[s]});
   endtask

   task automatic look_at(input logic [3:0] k, input logic [31:0] x);
      notes.push_back({k, x});
      look <= 1'b1;
      @(posedge i_core_clk);
      look <= 1'b0;
      @(posedge i_core_clk);
   endtask

   task automatic chk_stat();
      @(posedge i_core_clk);
      look_at(4'h1, exp_stat());
   endtask

   task automatic give_verdict();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Kind 0 is read data, 1 the enables, ratio and rate status, 2 the clock levels, 3 and 5 counts over a window, 4 the last tick gap.
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      core_q <= ck[3];
      if (ck[3] === 1'b1 && core_q === 1'b0) rises <= rises + 1;
      if (to_clk === 1'b1) begin
         pulses <= pulses + 1;
         gap <= cyc - last_to;
         last_to <= cyc;
      end
      if (rd_ph && hready === 1'b1 && o_hresp !== 1'b0) begin
         n_fail++;
         $display("FAIL t=%0t hresp got=%h exp=%h", $time, o_hresp, 1'b0);
      end
      if ((rd_ph && hready === 1'b1) || look) begin
         note = notes.pop_front();
         case (note[35:32])
            4'h0: obs = o_hrdata;
            4'h1: obs = {9'h0, en, ratio, rcode, rvalid};
            4'h2: obs = {28'h0, ck};
            4'h3: obs = 32'(rises - base);
            4'h4: obs = 32'(gap);
            default: obs = 32'(pulses - base);
         endcase
         checks_done++;
         if (obs !== note[31:0]) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, obs, note[31:0]);
         end
      end
   end

   initial begin
      // The longest period is 2048 cycles and is seen three times; the rest is far shorter.
      #(60000 * 100);
      n_fail++;
      give_verdict();
   end

   initial begin
      i_rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      rd_ph = 1'b0;
      look = 1'b0;
      lf = 16'd27518;
      for (int s = 0; s < 6; s++) sh[s] = cpc_pkg::REG_RESET[s];
      repeat (8) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      for (int s = 0; s < 6; s++) rd(s);
      chk_stat();
      for (int i = 0; i < 12; i++) begin
         lf = nxt_rand(lf);
         wr(i % 3, {lf, lf});
         rd(i % 3);
         chk_stat();
      end
      bus(1'b1, 32'h40, 32'hffff_ffff, 32'h0);
      bus(1'b0, 32'h40, 32'h0, 32'h0);
      for (int s = 0; s < 3; s++) rd(s);
      for (int c = 0; c < 10; c++) begin
         lf = nxt_rand(lf);
         wr(4, {lf, 2'h0, 4'(c), 7'h0, 3'(c % 6)});
         chk_stat();
      end
      rd(4);
      for (int m = 0; m < 8; m++) begin
         lf = nxt_rand(lf);
         wr(3, 32'(m[2]));
         wr(5, {16'h0, m[0], m[1], 10'h0, lf[2:0], 1'b0});
         repeat (20) @(posedge i_core_clk);
         for (int k = 0; k < 6 && m < 4; k++) begin
            e = m[1] ? ll_clk : (mclk ^ m[0]);
            look_at(4'h2, {28'h0, e, e & lf[1], e & lf[0], e & lf[2]});
         end
         base = rises;
         repeat (239) @(posedge i_core_clk);
         look_at(4'h3, 32'((m[1] ? 40 : 30) >> m[2]));
      end
      for (int t = 0; t < 8; t++) begin
         wr(3, {17'h0, t[2], t[1], 13'h0});
         wr(5, {19'h0, t[0], 12'h1});
         p0 = pulses;
         while (pulses < p0 + 3) @(posedge i_core_clk);
         look_at(4'h4, 32'((128 >> t[0]) * (t[2] ? 16 : 1) / (t[1] ? 4 : 1)));
      end
      wr(5, 32'h0);
      repeat (2) @(posedge i_core_clk);
      base = pulses;
      repeat (2999) @(posedge i_core_clk);
      look_at(4'h5, 32'h0);
      give_verdict();
   end
endmodule // testbench
